// file: logic/btdp_pkg.sv
// Package for the branch timing and dual data pointer block.
// Assumes a single core clock and an 8-bit special function register bus.
package btdp_pkg;
    localparam logic [7:0] ADDR_PTR_A_LOW   = 8'h82;
    localparam logic [7:0] ADDR_PTR_A_HIGH  = 8'h83;
    localparam logic [7:0] ADDR_PTR_B_LOW   = 8'h84;
    localparam logic [7:0] ADDR_PTR_B_HIGH  = 8'h85;
    localparam logic [7:0] ADDR_PTR_CHOICE  = 8'h86;
    localparam logic [7:0] ADDR_CLOCK_CTRL  = 8'h8E;

    localparam logic [7:0] RST_PTR          = 8'h00;
    localparam logic       RST_CHOICE       = 1'b0;
    localparam logic [7:0] RST_CLOCK_CTRL   = 8'h01;
    localparam logic [7:0] CHOICE_FIXED     = 8'h00;

    localparam int         STRETCH_LSB      = 0;
    localparam int         TIMER0_FAST_BIT  = 3;
    localparam int         TIMER1_FAST_BIT  = 4;
    localparam int         TIMER2_FAST_BIT  = 5;

    localparam logic [1:0] CLKS_PER_CYCLE   = 2'h3;
    localparam logic [3:0] TIMER_SLOW_DIV   = 4'hB;
    localparam logic [3:0] TIMER_FAST_DIV   = 4'h3;
    localparam logic [3:0] MOVE_BASE_CYCLES = 4'h2;

    localparam logic [7:0] OP_NO_OP         = 8'h00;
    localparam logic [7:0] OP_RESERVED_NOP  = 8'hA5;
    localparam logic [7:0] OP_LONG_CALL     = 8'h12;
    localparam logic [7:0] OP_SHORT_JUMP    = 8'h80;
    localparam logic [7:0] OP_JUMP_BIT_SET  = 8'h20;
    localparam logic [7:0] OP_JUMP_INDIRECT = 8'h73;
    localparam logic [7:0] OP_JUMP_ZERO     = 8'h60;
    localparam logic [7:0] OP_JUMP_NONZERO  = 8'h70;
    localparam logic [7:0] OP_CMP_IMM       = 8'hB4;
    localparam logic [7:0] OP_CMP_DIRECT    = 8'hB5;
    localparam logic [7:0] OP_DEC_DIRECT    = 8'hD5;
    localparam logic [4:0] OP_ABS_CALL_LOW  = 5'h11;
    localparam logic [3:0] OP_CMP_IND_HI    = 4'hB;
    localparam logic [2:0] OP_CMP_IND_LOW   = 3'h3;
    localparam logic [4:0] OP_CMP_REG_HI    = 5'h17;
    localparam logic [4:0] OP_DEC_REG_HI    = 5'h1B;

    localparam logic [7:0] OP_MOVE_EXT_A    = 8'hE0;
    localparam logic [7:0] OP_MOVE_EXT_B    = 8'hF0;
    localparam logic [7:0] OP_PRODUCT       = 8'hA4;
    localparam logic [7:0] OP_QUOTIENT      = 8'h84;
    localparam logic [2:0] PRODUCT_CYCLES   = 3'h5;

    typedef enum logic [3:0] {
        BTDP_CLS_OTHER, BTDP_CLS_NO_OP, BTDP_CLS_ABS_CALL, BTDP_CLS_LONG_CALL,
        BTDP_CLS_SHORT_JUMP, BTDP_CLS_JUMP_BIT, BTDP_CLS_JUMP_INDIRECT,
        BTDP_CLS_JUMP_ACC, BTDP_CLS_COMPARE, BTDP_CLS_DEC_REG, BTDP_CLS_DEC_DIRECT,
        BTDP_CLS_EXT_MOVE, BTDP_CLS_PRODUCT
    } btdp_class_t;

    typedef struct packed {
        btdp_class_t cls;
        logic [1:0]  bytes;
        logic [3:0]  cycles;
        logic        uses_pointer;
    } btdp_decode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } btdp_sfr_req_t;
endpackage

// file: logic/btdp_core.sv
// Decoder, instruction-cycle sequencer and dual data pointer registers.
// Assumes the core presents an opcode with a strobe and uses the SFR bus here.
`timescale 1ns/1ns
`default_nettype none
module btdp_core
    import btdp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire btdp_sfr_req_t sfr_req,
    output logic [7:0]         sfr_rdata,
    output logic               sfr_hit,
    input  wire logic          op_valid,
    input  wire logic [7:0]    op_code,
    output logic               op_ready,
    output btdp_decode_t       op_info,
    output logic               cycle_tick,
    output logic               instr_done,
    input  wire logic [7:0]    acc,
    output logic [15:0]        pointer_now,
    output logic [15:0]        jump_target,
    output logic               timer0_tick,
    output logic               timer1_tick,
    output logic               timer2_tick
);
    logic [7:0]   a_low_q, a_low_d, a_high_q, a_high_d;
    logic [7:0]   b_low_q, b_low_d, b_high_q, b_high_d;
    logic         choice_q, choice_d;
    logic [7:0]   clk_ctrl_q, clk_ctrl_d;
    logic [1:0]   phase_q, phase_d;
    logic [3:0]   left_q, left_d;
    logic         busy_q, busy_d;
    logic [3:0]   tdiv_q [3];
    logic [3:0]   tdiv_d [3];
    logic [2:0]   tick_q, tick_d;
    logic [15:0]  ptr_q, ptr_d;
    logic [15:0]  tgt_q, tgt_d;
    logic [7:0]   rdata_q, rdata_d;
    btdp_decode_t info_q, info_d, dec;
    logic         choice_wr;

    always_comb begin
        dec = '{cls: BTDP_CLS_OTHER, bytes: 2'h1, cycles: 4'h1, uses_pointer: 1'b0};
        if (op_code == OP_NO_OP || op_code == OP_RESERVED_NOP) begin
            dec = '{BTDP_CLS_NO_OP, 2'h1, 4'h1, 1'b0};
        end else if (op_code[4:0] == OP_ABS_CALL_LOW) begin
            dec = '{BTDP_CLS_ABS_CALL, 2'h2, 4'h3, 1'b0};
        end else if (op_code == OP_LONG_CALL) begin
            dec = '{BTDP_CLS_LONG_CALL, 2'h3, 4'h4, 1'b0};
        end else if (op_code == OP_SHORT_JUMP) begin
            dec = '{BTDP_CLS_SHORT_JUMP, 2'h2, 4'h3, 1'b0};
        end else if (op_code == OP_JUMP_BIT_SET) begin
            dec = '{BTDP_CLS_JUMP_BIT, 2'h3, 4'h4, 1'b0};
        end else if (op_code == OP_JUMP_INDIRECT) begin
            dec = '{BTDP_CLS_JUMP_INDIRECT, 2'h1, 4'h3, 1'b1};
        end else if (op_code == OP_JUMP_ZERO || op_code == OP_JUMP_NONZERO) begin
            dec = '{BTDP_CLS_JUMP_ACC, 2'h2, 4'h3, 1'b0};
        end else if (op_code == OP_CMP_IMM || op_code == OP_CMP_DIRECT
                     || (op_code[7:4] == OP_CMP_IND_HI && op_code[3:1] == OP_CMP_IND_LOW)
                     || op_code[7:3] == OP_CMP_REG_HI) begin
            dec = '{BTDP_CLS_COMPARE, 2'h3, 4'h4, 1'b0};
        end else if (op_code[7:3] == OP_DEC_REG_HI) begin
            dec = '{BTDP_CLS_DEC_REG, 2'h2, 4'h3, 1'b0};
        end else if (op_code == OP_DEC_DIRECT) begin
            dec = '{BTDP_CLS_DEC_DIRECT, 2'h3, 4'h4, 1'b0};
        end else if (op_code == OP_MOVE_EXT_A || op_code == OP_MOVE_EXT_B) begin
            // The stretch field widens the move up to nine cycles.
            dec = '{BTDP_CLS_EXT_MOVE, 2'h1,
                    4'(MOVE_BASE_CYCLES + {1'b0, clk_ctrl_q[STRETCH_LSB +: 3]}), 1'b1};
        end else if (op_code == OP_PRODUCT || op_code == OP_QUOTIENT) begin
            dec = '{BTDP_CLS_PRODUCT, 2'h1, {1'b0, PRODUCT_CYCLES}, 1'b0};
        end
    end

    assign op_ready   = !busy_q;
    assign cycle_tick = (phase_q == CLKS_PER_CYCLE);
    assign choice_wr  = sfr_req.wr && sfr_req.addr == ADDR_PTR_CHOICE;

    // Sequencer: a new opcode is taken on any clock while idle and restarts the cycle phase.
    always_comb begin
        phase_d = phase_q + 2'h1;
        busy_d  = busy_q;
        left_d  = left_q;
        info_d  = info_q;
        tgt_d   = tgt_q;
        instr_done = 1'b0;
        if (busy_q && cycle_tick) begin
            left_d = left_q - 4'h1;
            if (left_q == 4'h1) begin
                busy_d     = 1'b0;
                instr_done = 1'b1;
            end
        end else if (!busy_q && op_valid) begin
            busy_d = 1'b1;
            left_d = dec.cycles;
            info_d = dec;
            phase_d = 2'h0;
            tgt_d  = ptr_q + {8'h00, acc};
        end
    end

    // Pointer select feeds both pointer consumers; readback of other bits is fixed.
    always_comb begin
        a_low_d    = a_low_q;
        a_high_d   = a_high_q;
        b_low_d    = b_low_q;
        b_high_d   = b_high_q;
        choice_d   = choice_q;
        clk_ctrl_d = clk_ctrl_q;
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                ADDR_PTR_A_LOW:  a_low_d  = sfr_req.wdata;
                ADDR_PTR_A_HIGH: a_high_d = sfr_req.wdata;
                ADDR_PTR_B_LOW:  b_low_d  = sfr_req.wdata;
                ADDR_PTR_B_HIGH: b_high_d = sfr_req.wdata;
                ADDR_CLOCK_CTRL: clk_ctrl_d = sfr_req.wdata;
                default: ;
            endcase
        end
        if (choice_wr) begin
            choice_d = sfr_req.wdata[0];
        end
        ptr_d = choice_d ? {b_high_d, b_low_d} : {a_high_d, a_low_d};
        sfr_hit = 1'b1;
        case (sfr_req.addr)
            ADDR_PTR_A_LOW:  rdata_d = a_low_q;
            ADDR_PTR_A_HIGH: rdata_d = a_high_q;
            ADDR_PTR_B_LOW:  rdata_d = b_low_q;
            ADDR_PTR_B_HIGH: rdata_d = b_high_q;
            ADDR_PTR_CHOICE: rdata_d = {CHOICE_FIXED[7:1], choice_q};
            ADDR_CLOCK_CTRL: rdata_d = clk_ctrl_q;
            default: begin
                rdata_d = 8'h00;
                sfr_hit = 1'b0;
            end
        endcase
        if (!sfr_req.rd) begin
            rdata_d = rdata_q;
        end
    end

    // Each timer prescaler counts twelve clocks, or four when its fast bit is set.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            tdiv_d[i] = tdiv_q[i] - 4'h1;
            tick_d[i] = 1'b0;
            if (tdiv_q[i] == 4'h0) begin
                tick_d[i] = 1'b1;
                tdiv_d[i] = clk_ctrl_q[TIMER0_FAST_BIT + i] ? TIMER_FAST_DIV : TIMER_SLOW_DIV;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            a_low_q    <= RST_PTR;
            a_high_q   <= RST_PTR;
            b_low_q    <= RST_PTR;
            b_high_q   <= RST_PTR;
            choice_q   <= RST_CHOICE;
            clk_ctrl_q <= RST_CLOCK_CTRL;
            phase_q    <= 2'h0;
            left_q     <= 4'h0;
            busy_q     <= 1'b0;
            info_q     <= '{BTDP_CLS_OTHER, 2'h0, 4'h0, 1'b0};
            ptr_q      <= 16'h0000;
            tgt_q      <= 16'h0000;
            rdata_q    <= 8'h00;
            tick_q     <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                tdiv_q[i] <= TIMER_SLOW_DIV;
            end
        end else begin
            a_low_q    <= a_low_d;
            a_high_q   <= a_high_d;
            b_low_q    <= b_low_d;
            b_high_q   <= b_high_d;
            choice_q   <= choice_d;
            clk_ctrl_q <= clk_ctrl_d;
            phase_q    <= phase_d;
            left_q     <= left_d;
            busy_q     <= busy_d;
            info_q     <= info_d;
            ptr_q      <= ptr_d;
            tgt_q      <= tgt_d;
            rdata_q    <= rdata_d;
            tick_q     <= tick_d;
            tdiv_q     <= tdiv_d;
        end
    end

    assign sfr_rdata   = rdata_q;
    assign op_info     = info_q;
    assign pointer_now = ptr_q;
    assign jump_target = tgt_q;
    assign timer0_tick = tick_q[0];
    assign timer1_tick = tick_q[1];
    assign timer2_tick = tick_q[2];
endmodule
`default_nettype wire

// file: dv/btdp_properties.sv
// Concurrent checks on the decode, sequencing and register ports of btdp_core.
// Assumes a bind onto btdp_core and one clock domain with rstn as its reset.
`timescale 1ns/1ns
`default_nettype none
module btdp_properties
    import btdp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire btdp_sfr_req_t sfr_req,
    input  wire logic [7:0]    sfr_rdata,
    input  wire logic          sfr_hit,
    input  wire logic          op_valid,
    input  wire logic [7:0]    op_code,
    input  wire logic          op_ready,
    input  wire btdp_decode_t  op_info,
    input  wire logic          cycle_tick,
    input  wire logic          instr_done,
    input  wire logic [7:0]    acc,
    input  wire logic [15:0]   pointer_now,
    input  wire logic [15:0]   jump_target,
    input  wire logic          timer1_tick
);
    logic take;
    assign take = op_valid && op_ready;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    phase_four_a: assert property (take |-> ##1 !cycle_tick [*3] ##1 cycle_tick)
        else $error("instruction cycle not four clocks");
    done_on_tick_a: assert property (instr_done |-> cycle_tick)
        else $error("done outside a cycle boundary");
    busy_refuse_a: assert property (take |=> !op_ready)
        else $error("ready while busy");
    idle_nop_a: assert property (take && (op_code == 8'h00 || op_code == 8'hA5) |-> ##4 instr_done)
        else $error("no-op not one cycle");
    short_jump_a: assert property (take && op_code == 8'h80 |-> ##12 instr_done)
        else $error("short jump not three cycles");
    long_call_a: assert property (take && op_code == 8'h12 |=> op_info.bytes == 2'h3 && op_info.cycles == 4'h4)
        else $error("long call decode wrong");
    sfr_map_a: assert property (sfr_hit == (sfr_req.addr inside {[8'h82:8'h86], 8'h8E}))
        else $error("register map hit wrong");
    choice_bits_a: assert property (sfr_req.rd && sfr_req.addr == 8'h86 |=> sfr_rdata[7:1] == 7'h00)
        else $error("unused select bits not zero");
    indirect_sum_a: assert property (take && op_code == 8'h73 |=> jump_target == {8'h00, $past(acc)} + $past(pointer_now))
        else $error("indirect target wrong");
    slow_timer_a: assert property (timer1_tick |-> ##12 timer1_tick)
        else $error("slow timer rate wrong");
endmodule
bind btdp_core btdp_properties u_props (.clk(clk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready), .op_info(op_info),
    .cycle_tick(cycle_tick), .instr_done(instr_done), .acc(acc), .pointer_now(pointer_now),
    .jump_target(jump_target), .timer1_tick(timer1_tick));
`default_nettype wire

// file: dv/btdp_core_tb_top.sv
// Self-checking bench for btdp_core: register access, opcode timing and timer rates.
// Assumes the core clock at 125 MHz and inputs driven on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module btdp_core_tb_top
    import btdp_pkg::*;
;
    logic          clk;
    logic          rstn;
    btdp_sfr_req_t req;
    logic [7:0]    sfr_rdata;
    logic          sfr_hit;
    logic          op_valid;
    logic [7:0]    op_code;
    logic          op_ready;
    btdp_decode_t  op_info;
    logic          cycle_tick;
    logic          instr_done;
    logic [7:0]    acc;
    logic [15:0]   pointer_now;
    logic [15:0]   jump_target;
    logic [2:0]    tmr;
    int            error_cnt = 0;
    int            checked = 0;
    int            cyc = 0;
    int            i;
    time           t0;
    logic [15:0]   ops [20] = '{16'h0011, 16'hA511, 16'h1123, 16'hF123, 16'h1234, 16'h8023, 16'h2034,
        16'h7313, 16'h6023, 16'h7023, 16'hB434, 16'hB534, 16'hB634, 16'hB734, 16'hB834, 16'hBF34,
        16'hD823, 16'hDF23, 16'hD534, 16'hA415};

    btdp_core u_dut (.clk(clk), .rstn(rstn), .sfr_req(req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready), .op_info(op_info),
        .cycle_tick(cycle_tick), .instr_done(instr_done), .acc(acc), .pointer_now(pointer_now),
        .jump_target(jump_target), .timer0_tick(tmr[0]), .timer1_tick(tmr[1]), .timer2_tick(tmr[2]));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
        // An idle cycle keeps back-to-back calls from touching the strobe twice in one step.
        @(negedge clk);
    endtask

    // The address stays put after the read so the hit flag is still valid.
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req.rd = 1'b0;
        chk({8'h00, sfr_rdata}, {8'h00, exp});
        chk({15'h0000, sfr_hit}, {15'h0000, hit});
        @(negedge clk);
    endtask

    // Counts clocks from the taking edge to the cycle that shows completion.
    task automatic run_op(input logic [7:0] op, input logic [1:0] b, input logic [3:0] c);
        int n;
        op_valid = 1'b1;
        op_code = op;
        n = 0;
        while (op_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        op_valid = 1'b0;
        chk({10'h000, op_info.bytes, op_info.cycles}, {10'h000, b, c});
        n = 1;
        while (instr_done !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n), {10'h000, c, 2'b00});
    endtask

    task automatic end_of_test();
        $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        req = '0;
        op_valid = 1'b0;
        op_code = 8'h00;
        acc = 8'h10;
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        for (i = 0; i < 5; i++) begin
            sfr_rd(8'h82 + 8'(i), 8'h00, 1'b1);
        end
        sfr_rd(8'h8E, 8'h01, 1'b1);
        sfr_rd(8'h87, 8'h00, 1'b0);
        run_op(8'hE0, 2'h1, 4'h3);
        sfr_wr(8'h82, 8'h34);
        sfr_wr(8'h83, 8'h12);
        sfr_wr(8'h84, 8'hCD);
        sfr_wr(8'h85, 8'hAB);
        sfr_wr(8'h86, 8'hFF);
        chk(pointer_now, 16'hABCD);
        sfr_rd(8'h86, 8'h01, 1'b1);
        sfr_rd(8'h82, 8'h34, 1'b1);
        sfr_rd(8'h85, 8'hAB, 1'b1);
        run_op(8'h73, 2'h1, 4'h3);
        chk(jump_target, 16'hABDD);
        sfr_wr(8'h86, 8'h02);
        chk(pointer_now, 16'h1234);
        for (i = 0; i < 20; i++) begin
            run_op(ops[i][15:8], ops[i][5:4], ops[i][3:0]);
        end
        for (i = 0; i < 8; i++) begin
            sfr_wr(8'h8E, 8'(i));
            run_op(i[0] ? 8'hF0 : 8'hE0, 2'h1, 4'(2 + i));
        end
        // A reset in mid-run must bring the registers back to their reset values.
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        sfr_rd(8'h8E, 8'h01, 1'b1);
        sfr_rd(8'h84, 8'h00, 1'b1);
        sfr_rd(8'h86, 8'h00, 1'b1);
        sfr_wr(8'h8E, 8'h28);
        for (i = 0; i < 3; i++) begin
            repeat (2) @(posedge tmr[i]);
            t0 = $time;
            @(posedge tmr[i]);
            chk(16'(($time - t0) / 8), (i == 1) ? 16'h000C : 16'h0004);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
